// file: shared/osc_ctrl_pkg.sv
// constants and types shared by the internal oscillator control block
package osc_ctrl_pkg;

  // register addresses on the special-function bus
  localparam logic [7:0] HF_CTRL_ADDR      = 8'hB2;  // hf_osc_control
  localparam logic [7:0] MULT_COMPAT_ADDR  = 8'hB9;  // multiplier_compat_status

  // hf_osc_control field positions
  localparam int         HF_EN_BIT         = 7;      // hf_osc_enable
  localparam int         HF_RDY_BIT        = 6;      // hf_freq_ready, read only
  localparam int         HF_SUSP_BIT       = 5;      // suspend request
  localparam int         HF_DIV_LSB        = 0;      // hf_system_clock_divider low bit
  localparam int         HF_DIV_W          = 2;      // hf_system_clock_divider width

  // reset values
  localparam logic [7:0] HF_CTRL_RESET     = 8'hC0;  // enabled and ready
  localparam logic [1:0] HF_DIV_RESET      = 2'h0;   // divide by 8
  localparam logic [7:0] MULT_COMPAT_VALUE = 8'hE0;  // enable, init, ready set; select 00

  // oscillator figures
  localparam int         HF_OSC_FREQ_HZ    = 48_000_000; // feeds usb directly
  localparam logic [5:0] HF_PRE_DIVIDE     = 6'h04;      // fixed stage before divider
  localparam int         LF_OSC_FREQ_HZ    = 80_000;     // nominal low-frequency rate
  localparam int         CLK_FREQ_HZ       = 10_000_000; // block clock

  // divider field encodings, shared by both dividers
  localparam logic [1:0] DIV_BY8           = 2'h0;
  localparam logic [1:0] DIV_BY4           = 2'h1;
  localparam logic [1:0] DIV_BY2           = 2'h2;
  localparam logic [1:0] DIV_BY1           = 2'h3;

  // number of capture timers (timer 2 at index 0, timer 3 at index 1)
  localparam int         NUM_CAP_TIMERS    = 2;

  // high-frequency oscillator state, gray along off-start-run-suspend
  typedef enum logic [1:0] {
    OSC_OFF       = 2'h0,
    OSC_STARTING  = 2'h1,
    OSC_RUNNING   = 2'h3,
    OSC_SUSPENDED = 2'h2
  } osc_state_type;

endpackage

// file: shared/lf_capture_if.sv
// carries the low-frequency divider setting and its output edges
`timescale 1ns/1ps
interface lf_capture_if;
  logic [1:0] div_sel;    // divider field
  logic       div_level;  // divided oscillator level
  logic       rise;       // one-cycle pulse on rising edge
  logic       fall;       // one-cycle pulse on falling edge
  modport prov (input div_sel, output div_level, output rise, output fall);
  modport cons (output div_sel, input div_level, input rise, input fall);
endinterface

// file: rtl/lf_divider_edge.sv
// low-frequency oscillator synchroniser, divider and edge detector
`timescale 1ns/1ps
module lf_divider_edge
  import osc_ctrl_pkg::*;
(
  input  wire logic   clk,        // block clock
  input  wire logic   nrst,       // async reset, active low
  input  wire logic   lf_osc_pin, // raw oscillator output
  lf_capture_if.prov  cap         // divider setting in, edges out
);

  logic       sync1_r;    // first synchroniser stage
  logic       sync2_r;    // second synchroniser stage
  logic       prev_osc_r; // last synced level
  logic [2:0] cnt_r;      // binary count of oscillator rising edges
  logic       level_nxt;  // selected divider tap
  logic       level_r;    // registered divided level
  logic       rise_r;     // rising edge pulse
  logic       fall_r;     // falling edge pulse

  // two-stage synchroniser
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= lf_osc_pin;
      sync2_r <= sync1_r;
    end
  end

  // count oscillator rising edges, each bit halves the rate
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_osc_r <= 1'b0;
      cnt_r      <= 3'h0;
    end else begin
      prev_osc_r <= sync2_r;
      if (sync2_r && !prev_osc_r) begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end

  // pick the tap for the chosen ratio
  always_comb begin
    unique case (cap.div_sel)
      DIV_BY8: level_nxt = cnt_r[2]; // [RL11] [RL12]
      DIV_BY4: level_nxt = cnt_r[1]; // [RL12]
      DIV_BY2: level_nxt = cnt_r[0]; // [RL12]
      DIV_BY1: level_nxt = sync2_r;  // [RL12]
    endcase
  end

  // divided level and its edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level_r <= 1'b0;
      rise_r  <= 1'b0;
      fall_r  <= 1'b0;
    end else begin
      level_r <= level_nxt;
      rise_r  <= level_nxt && !level_r;
      fall_r  <= !level_nxt && level_r;
    end
  end

  assign cap.div_level = level_r;
  assign cap.rise      = rise_r;
  assign cap.fall      = fall_r;

  // an edge pulse always agrees with the divided level in the same cycle
  edge_level_a: assert property (@(posedge clk) disable iff (!nrst) // [RL14]
    (rise_r |-> level_r) and (fall_r |-> !level_r))
    else $error("edge pulse disagrees with divided level");

endmodule // lf_divider_edge

// file: rtl/internal_oscillator_control.sv
// internal oscillator control and status with low-frequency capture path
//
// Contract
// RL1: hf oscillator runs only while enable bit set
// RL2: ready bit shows oscillator at programmed frequency
// RL3: writing suspend bit halts the oscillator
// RL4: usb activity or vbus edge wakes oscillator
// RL5: system_clock divided by 4 then 8/4/2/1
// RL6: unused bits 4:2 read zero, writes ignored
// RL7: 48 MHz oscillator feeds usb directly
// RL8: multiplier register reports present, working multiplier
// RL9: multiplier enable, init, ready always read 1
// RL10: multiplier input select always reads 00
// RL11: lf oscillator 80 kHz with selectable divider
// RL12: lf divider codes 00=8,01=4,10=2,11=1
// RL13: 4-bit fine-tune adjusts lf frequency
// RL14: timer 2 captures falling, timer 3 rising
// RL15: capture copies count into reload pair
// RL16: ready drops while disabled or suspended
`timescale 1ns/1ps
module internal_oscillator_control
  import osc_ctrl_pkg::*;
(
  input  wire logic                              clk,                  // 10 MHz block clock
  input  wire logic                              nrst,                 // async reset, active low
  input  wire logic [7:0]                        sfr_addr,             // register address
  input  wire logic                              sfr_wr,               // write strobe
  input  wire logic [7:0]                        sfr_wdata,            // write data
  input  wire logic                              sfr_rd,               // read strobe
  output      logic [7:0]                        sfr_rdata,            // read data, one cycle after strobe
  input  wire logic                              hf_osc_stable,        // analog oscillator settled
  input  wire logic                              usb_non_idle,         // usb bus activity level
  input  wire logic                              vbus,                 // vbus sense
  input  wire logic                              lf_osc_pin,           // low-frequency oscillator output
  input  wire logic [1:0]                        lf_divider_select,    // low-frequency divider field
  input  wire logic [3:0]                        lf_fine_tune,         // low-frequency trim field
  input  wire logic [NUM_CAP_TIMERS-1:0]         timer_capture_mode,   // capture mode per timer
  input  wire logic [NUM_CAP_TIMERS-1:0][15:0]   timer_count_pair,     // live timer counts
  output      logic                              hf_osc_run,           // oscillator enable to analog
  output      logic                              hf_freq_ready,        // oscillator ready status
  output      logic [5:0]                        hf_system_clock_ratio,      // total oscillator to system_clock ratio
  output      logic                              usb_clock_direct,     // usb clock available unmultiplied
  output      logic [3:0]                        lf_trim,              // trim to lf oscillator
  output      logic                              lf_divided_out,       // divided lf oscillator
  output      logic [NUM_CAP_TIMERS-1:0][15:0]   timer_reload_pair,    // captured counts
  output      logic [NUM_CAP_TIMERS-1:0]         timer_capture_strobe  // one-cycle capture pulse
);

  lf_capture_if cap_if ();                              // link to divider module

  logic                                osc_en_r;        // hf_osc_enable
  logic                                susp_r;          // suspend request
  logic [HF_DIV_W-1:0]                 div_r;           // hf_system_clock_divider
  osc_state_type                       osc_state_r;     // oscillator state
  osc_state_type                       osc_state_nxt;   // next oscillator state
  logic                                stable_s1_r;     // stable sync stage 1
  logic                                stable_s2_r;     // stable sync stage 2
  logic                                usb_s1_r;        // usb sync stage 1
  logic                                usb_s2_r;        // usb sync stage 2
  logic                                vbus_s1_r;       // vbus sync stage 1
  logic                                vbus_s2_r;       // vbus sync stage 2
  logic                                vbus_prev_r;     // vbus last synced level
  logic                                wake_evt;        // any wake-up event this cycle
  logic                                hf_wr;           // write to hf_osc_control
  logic [7:0]                          rdata_r;         // read data register
  logic                                run_r;           // oscillator enable output
  logic                                rdy_r;           // ready output
  logic [5:0]                          ratio_r;         // total divide ratio
  logic [5:0]                          ratio_nxt;       // ratio for current field
  logic                                usb_direct_r;    // usb clock flag
  logic [3:0]                          trim_r;          // fine-tune output
  logic [NUM_CAP_TIMERS-1:0][15:0]     reload_r;        // captured counts
  logic [NUM_CAP_TIMERS-1:0]           strobe_r;        // capture pulses
  logic [NUM_CAP_TIMERS-1:0]           cap_edge;        // edge per timer

  assign hf_wr = sfr_wr && (sfr_addr == HF_CTRL_ADDR);

  // synchronise pins before any logic looks at them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stable_s1_r <= 1'b0;
      stable_s2_r <= 1'b0;
      usb_s1_r    <= 1'b0;
      usb_s2_r    <= 1'b0;
      vbus_s1_r   <= 1'b0;
      vbus_s2_r   <= 1'b0;
      vbus_prev_r <= 1'b0;
    end else begin
      stable_s1_r <= hf_osc_stable;
      stable_s2_r <= stable_s1_r;
      usb_s1_r    <= usb_non_idle;
      usb_s2_r    <= usb_s1_r;
      vbus_s1_r   <= vbus;
      vbus_s2_r   <= vbus_s1_r;
      vbus_prev_r <= vbus_s2_r;
    end
  end

  // usb activity or either vbus edge ends suspend
  assign wake_evt = usb_s2_r || (vbus_s2_r != vbus_prev_r); // [RL4]

  // writable fields of hf_osc_control; bits 4:2 have no storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_en_r <= HF_CTRL_RESET[HF_EN_BIT];
      div_r    <= HF_DIV_RESET;
    end else if (hf_wr) begin
      osc_en_r <= sfr_wdata[HF_EN_BIT];                      // [RL1]
      div_r    <= sfr_wdata[HF_DIV_LSB +: HF_DIV_W];         // [RL5]
    end
  end

  // suspend request: a wake event beats a simultaneous set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      susp_r <= HF_CTRL_RESET[HF_SUSP_BIT];
    end else if (wake_evt) begin
      susp_r <= 1'b0;                                        // [RL4]
    end else if (hf_wr && sfr_wdata[HF_SUSP_BIT]) begin
      susp_r <= 1'b1;                                        // [RL3]
    end
  end

  // oscillator state follows enable, suspend and settling
  always_comb begin
    osc_state_nxt = osc_state_r;
    if (!osc_en_r) begin
      osc_state_nxt = OSC_OFF;                               // [RL1]
    end else if (susp_r) begin
      osc_state_nxt = OSC_SUSPENDED;                         // [RL3]
    end else begin
      unique case (osc_state_r)
        OSC_OFF:       osc_state_nxt = OSC_STARTING;
        OSC_SUSPENDED: osc_state_nxt = OSC_STARTING;         // [RL16]
        OSC_STARTING:  osc_state_nxt = stable_s2_r ? OSC_RUNNING : OSC_STARTING;
        OSC_RUNNING:   osc_state_nxt = OSC_RUNNING;
      endcase
    end
  end

  // state register, out of reset already running
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_state_r <= OSC_RUNNING;
    end else begin
      osc_state_r <= osc_state_nxt;
    end
  end

  // total system_clock ratio: fixed pre-divide times field ratio
  always_comb begin
    unique case (div_r)
      DIV_BY8: ratio_nxt = HF_PRE_DIVIDE << 3;               // [RL5]
      DIV_BY4: ratio_nxt = HF_PRE_DIVIDE << 2;
      DIV_BY2: ratio_nxt = HF_PRE_DIVIDE << 1;
      DIV_BY1: ratio_nxt = HF_PRE_DIVIDE;
    endcase
  end

  // registered status outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_r        <= 1'b1;
      rdy_r        <= 1'b1;
      ratio_r      <= HF_PRE_DIVIDE << 3;
      usb_direct_r <= 1'b1;
      trim_r       <= 4'h0;
    end else begin
      run_r        <= (osc_state_nxt != OSC_OFF) && (osc_state_nxt != OSC_SUSPENDED); // [RL1] [RL3]
      rdy_r        <= (osc_state_nxt == OSC_RUNNING);        // [RL2] [RL16]
      ratio_r      <= ratio_nxt;
      usb_direct_r <= (osc_state_nxt == OSC_RUNNING);        // [RL7]
      trim_r       <= lf_fine_tune;                          // [RL13]
    end
  end

  // register reads; unmapped addresses return zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else if (sfr_rd) begin
      if (sfr_addr == HF_CTRL_ADDR) begin
        rdata_r <= {osc_en_r, osc_state_r == OSC_RUNNING, susp_r, 3'h0, div_r}; // [RL2] [RL6]
      end else if (sfr_addr == MULT_COMPAT_ADDR) begin
        rdata_r <= MULT_COMPAT_VALUE;                        // [RL8] [RL9] [RL10]
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  // low-frequency divider and edge detection
  assign cap_if.div_sel = lf_divider_select;                 // [RL11]
  lf_divider_edge u_lf (
    .clk        (clk),
    .nrst       (nrst),
    .lf_osc_pin (lf_osc_pin),
    .cap        (cap_if.prov)
  );

  assign cap_edge[0] = cap_if.fall;                          // [RL14]
  assign cap_edge[1] = cap_if.rise;                          // [RL14]

  // per-timer capture of the live count on its edge
  for (genvar t = 0; t < NUM_CAP_TIMERS; t++) begin : g_cap
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        reload_r[t] <= 16'h0000;
        strobe_r[t] <= 1'b0;
      end else begin
        strobe_r[t] <= timer_capture_mode[t] && cap_edge[t];
        if (timer_capture_mode[t] && cap_edge[t]) begin
          reload_r[t] <= timer_count_pair[t];                // [RL15]
        end
      end
    end
  end

  assign sfr_rdata            = rdata_r;
  assign hf_osc_run           = run_r;
  assign hf_freq_ready        = rdy_r;
  assign hf_system_clock_ratio      = ratio_r;
  assign usb_clock_direct     = usb_direct_r;
  assign lf_trim              = trim_r;
  assign lf_divided_out       = cap_if.div_level;
  assign timer_reload_pair    = reload_r;
  assign timer_capture_strobe = strobe_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  disable_stops_osc_a: assert property (hf_wr && !sfr_wdata[HF_EN_BIT] |=> ##1 !hf_osc_run && !hf_freq_ready) // [RL1]
    else $error("oscillator still runs after disable");
  ready_readback_a: assert property (sfr_rd && sfr_addr == HF_CTRL_ADDR |=> // [RL2]
    sfr_rdata[HF_RDY_BIT] == ($past(osc_state_r) == OSC_RUNNING))
    else $error("ready bit disagrees with state");
  suspend_halts_a: assert property (hf_wr && sfr_wdata[HF_EN_BIT] && sfr_wdata[HF_SUSP_BIT] && !wake_evt |=> // [RL3]
    ##1 !hf_osc_run)
    else $error("suspend did not halt oscillator");
  wake_clears_a: assert property (susp_r && wake_evt |=> !susp_r) // [RL4]
    else $error("wake event did not end suspend");
  system_clock_ratio_a: assert property (hf_wr |=> ##1 hf_system_clock_ratio == // [RL5]
    (HF_PRE_DIVIDE << (2'h3 - $past(sfr_wdata[1:0], 2))))
    else $error("system_clock ratio wrong for divider field");
  unused_zero_a: assert property (sfr_rd |=> sfr_rdata[4:2] == 3'h0) // [RL6]
    else $error("unused bits read nonzero");
  mult_compat_a: assert property (sfr_rd && sfr_addr == MULT_COMPAT_ADDR |=> sfr_rdata == 8'hE0) // [RL9] [RL10]
    else $error("multiplier register not constant");
  capture_copy_a: assert property (timer_capture_strobe[0] |-> // [RL15]
    timer_reload_pair[0] == $past(timer_count_pair[0]))
    else $error("timer 2 reload not the captured count");
  capture_edge_a: assert property (timer_capture_strobe[1] |-> $past(cap_if.rise) && $past(timer_capture_mode[1])) // [RL14]
    else $error("timer 3 captured without rising edge");
  ready_low_a: assert property (!hf_osc_run |-> !hf_freq_ready) // [RL16]
    else $error("ready while oscillator halted");

  suspend_wake_c: cover property (susp_r ##1 !susp_r [*3] ##[1:100] hf_freq_ready);
  capture_c:      cover property (timer_capture_strobe[1] ##[1:1000] timer_capture_strobe[0]);
  disable_c:      cover property (hf_osc_run ##1 !hf_osc_run);

endmodule // internal_oscillator_control

// file: testbench/tb.sv
// self-checking testbench for the internal oscillator control block
`timescale 1ns/1ps
module tb;
  import osc_ctrl_pkg::*;
  logic                            clk;                  // 10 MHz bench clock
  logic                            nrst;                 // reset, active low
  logic [7:0]                      sfr_addr;             // register address
  logic                            sfr_wr;               // write strobe
  logic [7:0]                      sfr_wdata;            // write data
  logic                            sfr_rd;               // read strobe
  logic [7:0]                      sfr_rdata;            // read data
  logic                            hf_osc_stable;        // analog settled flag
  logic                            usb_non_idle;         // usb activity
  logic                            vbus;                 // vbus sense
  logic                            lf_osc_pin;           // low-frequency waveform
  logic [1:0]                      lf_divider_select;    // lf divider field
  logic [3:0]                      lf_fine_tune;         // lf trim field
  logic [NUM_CAP_TIMERS-1:0]       timer_capture_mode;   // capture mode per timer
  logic [NUM_CAP_TIMERS-1:0][15:0] timer_count_pair;     // live counts
  logic                            hf_osc_run;           // oscillator enable out
  logic                            hf_freq_ready;        // ready status
  logic [5:0]                      hf_system_clock_ratio;      // total divide ratio
  logic                            usb_clock_direct;     // usb clock unmultiplied
  logic [3:0]                      lf_trim;              // trim out
  logic                            lf_divided_out;       // divided lf waveform
  logic [NUM_CAP_TIMERS-1:0][15:0] timer_reload_pair;    // captured counts
  logic [NUM_CAP_TIMERS-1:0]       timer_capture_strobe; // capture pulses
  int                              n_errors;             // mismatches
  int                              samples_checked;      // comparisons made
  int                              div_rises;            // rising edges of divided output

  internal_oscillator_control i_dut (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .hf_osc_stable(hf_osc_stable),
    .usb_non_idle(usb_non_idle), .vbus(vbus), .lf_osc_pin(lf_osc_pin), .lf_divider_select(lf_divider_select),
    .lf_fine_tune(lf_fine_tune), .timer_capture_mode(timer_capture_mode), .timer_count_pair(timer_count_pair),
    .hf_osc_run(hf_osc_run), .hf_freq_ready(hf_freq_ready), .hf_system_clock_ratio(hf_system_clock_ratio),
    .usb_clock_direct(usb_clock_direct), .lf_trim(lf_trim), .lf_divided_out(lf_divided_out),
    .timer_reload_pair(timer_reload_pair), .timer_capture_strobe(timer_capture_strobe));

  // clock, 100 ns period
  always #50 clk = ~clk;

  // counts edges of the divided waveform
  always @(posedge lf_divided_out) div_rises++;

  // single compare for every kind of result
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // verdict and end of run
  task end_of_test;
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one register write, driven between falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
    @(negedge clk) sfr_wr = 1'b0;
  endtask

  // one register read, compared after the answer edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a; sfr_rd = 1'b1;
    @(negedge clk) sfr_rd = 1'b0;
    @(negedge clk) chk(sfr_rdata, exp, "read");
  endtask

  // picks a status output by number
  function automatic logic pick(input int sel);
    case (sel)
      0: return hf_osc_run;
      1: return hf_freq_ready;
      2: return timer_capture_strobe[0];
      default: return timer_capture_strobe[1];
    endcase
  endfunction

  // bounded wait for a status output to go high
  task automatic wait_hi(input int sel, input int lim);
    int i;
    for (i = 0; i < lim && pick(sel) !== 1'b1; i++) @(negedge clk);
    chk(pick(sel), 1'b1, "wait");
  endtask

  // values straight out of reset
  task t_reset;
    chk({hf_osc_run, hf_freq_ready, usb_clock_direct}, 3'b111, "reset status");
    chk(hf_system_clock_ratio, 6'h20, "reset ratio");
    rd(HF_CTRL_ADDR, 8'hC0);
    rd(MULT_COMPAT_ADDR, 8'hE0);
  endtask

  // read-only places ignore writes
  task t_ignored;
    wr(MULT_COMPAT_ADDR, 8'h1F);
    rd(MULT_COMPAT_ADDR, 8'hE0);
    wr(HF_CTRL_ADDR, 8'hDC);
    rd(HF_CTRL_ADDR, 8'hC0);
  endtask

  // every divider code and its ratio
  task t_divider;
    logic [5:0] r [4] = '{6'h20, 6'h10, 6'h08, 6'h04};
    for (int d = 0; d < 4; d++) begin
      wr(HF_CTRL_ADDR, 8'h80 | 8'(d));
      repeat (2) @(negedge clk);
      chk(hf_system_clock_ratio, r[d], "system_clock ratio");
      rd(HF_CTRL_ADDR, 8'hC0 | 8'(d));
    end
  endtask

  // disable, then re-enable with a late settle
  task t_enable;
    wr(HF_CTRL_ADDR, 8'h01);
    repeat (2) @(negedge clk);
    chk({hf_osc_run, hf_freq_ready, usb_clock_direct}, 3'b000, "disabled");
    rd(HF_CTRL_ADDR, 8'h01);
    hf_osc_stable = 1'b0;
    wr(HF_CTRL_ADDR, 8'h81);
    wait_hi(0, 6);
    repeat (10) @(negedge clk);
    chk(hf_freq_ready, 1'b0, "ready before settle");
    hf_osc_stable = 1'b1;
    wait_hi(1, 8);
    rd(HF_CTRL_ADDR, 8'hC1);
  endtask

  // suspend, woken once by usb activity and once by a vbus edge
  task t_suspend;
    for (int k = 0; k < 2; k++) begin
      wr(HF_CTRL_ADDR, 8'hA2);
      repeat (2) @(negedge clk);
      chk({hf_osc_run, hf_freq_ready}, 2'b00, "suspended");
      rd(HF_CTRL_ADDR, 8'hA2);
      repeat (5) @(negedge clk);
      chk(hf_osc_run, 1'b0, "stays halted");
      if (k == 0) usb_non_idle = 1'b1;
      else vbus = ~vbus;
      repeat (3) @(negedge clk);
      usb_non_idle = 1'b0;
      wait_hi(0, 8);
      wait_hi(1, 8);
      rd(HF_CTRL_ADDR, 8'hC2);
    end
  endtask

  // lf waveform, n half periods of 10 clocks each, well below clk/2
  task automatic lf_cycles(input int n);
    repeat (n) begin
      repeat (10) @(negedge clk);
      lf_osc_pin = ~lf_osc_pin;
    end
  endtask

  // divider ratios on the low-frequency path and the trim path
  task t_lf_div;
    int exp [4] = '{2, 4, 8, 16};
    for (int d = 0; d < 4; d++) begin
      lf_divider_select = 2'(d);
      lf_osc_pin = 1'b0;
      repeat (20) @(negedge clk);
      div_rises = 0;
      lf_cycles(32);
      repeat (10) @(negedge clk);
      chk(16'(div_rises), 16'(exp[d]), "lf divide");
    end
    lf_fine_tune = 4'hA;
    repeat (2) @(negedge clk);
    chk(lf_trim, 4'hA, "trim");
  endtask

  // capture on rising and falling lf edges, then with mode off
  task t_capture;
    lf_divider_select = 2'h3;
    timer_capture_mode = 2'b11;
    timer_count_pair = {16'h5678, 16'h1234};
    repeat (10) @(negedge clk);
    lf_osc_pin = 1'b1;
    wait_hi(3, 10);
    chk(timer_capture_strobe[0], 1'b0, "no fall capture");
    @(negedge clk) chk(timer_reload_pair[1], 16'h5678, "rise reload");
    timer_count_pair = {16'h4321, 16'hABCD};
    repeat (10) @(negedge clk);
    lf_osc_pin = 1'b0;
    wait_hi(2, 10);
    @(negedge clk) chk(timer_reload_pair[0], 16'hABCD, "fall reload");
    chk(timer_reload_pair[1], 16'h5678, "rise reload kept");
    timer_count_pair = {16'h0F0F, 16'hF0F0};
    timer_capture_mode = 2'b00;
    lf_cycles(4);
    chk(timer_reload_pair[0], 16'hABCD, "mode off timer 2");
    chk(timer_reload_pair[1], 16'h5678, "mode off timer 3");
  endtask

  // watchdog, well beyond the expected run
  initial begin
    #(20000 * 100);
    n_errors++;
    end_of_test();
  end

  // main sequence
  initial begin
    clk = 1'b0; nrst = 1'b0; sfr_addr = 8'h00; sfr_wr = 1'b0; sfr_wdata = 8'h00; sfr_rd = 1'b0;
    hf_osc_stable = 1'b1; usb_non_idle = 1'b0; vbus = 1'b0; lf_osc_pin = 1'b0;
    lf_divider_select = 2'h0; lf_fine_tune = 4'h0; timer_capture_mode = 2'b00;
    timer_count_pair = '0; n_errors = 0; samples_checked = 0; div_rises = 0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    t_reset();
    t_ignored();
    t_divider();
    t_enable();
    t_suspend();
    t_lf_div();
    t_capture();
    end_of_test();
  end
endmodule // tb
